//--- memory_map_config_regs.vh
// Register indexes, field positions and reset values for the memory map configuration bank
`ifndef MEMORY_MAP_CONFIG_REGS_VH
`define MEMORY_MAP_CONFIG_REGS_VH

// Register indexes; the byte address inside the block is four times the index
`define IDX_EEPROM_POSITION      8'h12
`define IDX_SYSTEM_EXTRAS        8'h13
`define IDX_TEST_LOCATION_A      8'h14
`define IDX_TEST_LOCATION_B      8'h17
`define IDX_MEMORY_ALLOC_INFO    8'h1C

// Eeprom position register fields
`define EE_BASE_MSB              7
`define EE_BASE_LSB              3
`define EE_ENABLE_BIT            0
`define EE_POSITION_RESET        8'h01

// System extras control register fields
`define MISC_STRETCH_MSB         3
`define MISC_STRETCH_LSB         2
`define MISC_UPPER_HALF_BIT      1
`define MISC_FLASH_ENABLE_BIT    0
`define MISC_STRETCH_RESET       2'h3
`define MISC_UPPER_HALF_RESET    1'h0
`define MISC_UPPER_NIBBLE        4'h0

// Memory allocation info fields
`define MEM_REG_SW_BIT           7
`define MEM_EEP_SW_MSB           5
`define MEM_EEP_SW_LSB           4
`define MEM_RAM_SW_MSB           2
`define MEM_RAM_SW_LSB           0

// Ram position register fields as seen at the ram_position_reg input
`define RAM_POS_MSB              7
`define RAM_POS_LSB              3
`define RAM_HAL_BIT              0

// Region sizes in bytes
`define SIZE_2K                  16'h0800
`define SIZE_4K                  16'h1000
`define SIZE_8K                  16'h2000
`define SIZE_16K                 16'h4000

// Bus field values
`define PAGE_BITS                11
`define TEST_VALUE_RESET         8'h00
`define ZERO_16                  16'h0000
`define ZERO_24                  24'h000000
`define ZERO_2                   2'h0
`define ONE_4                    4'h1

`endif

//--- memory_map_config_regs.v
// APB register bank for memory mapping configuration: eeprom position, extras, sizes
//
// Behaviour
// - Eeprom field bits 7:3 give base upper bits
// - Eeprom enable clear removes eeprom from map
// - Eeprom enable bit writable anytime, all modes
// - Eeprom field anytime, or optionally write-once
// - Register writes reach the control outputs one cycle later
// - Stretch field adds zero to three clocks
// - Stretch ignored in single-chip and peripheral modes
// - Extras fields write-once unless special mode
// - Upper-half bit blocks direct lower flash access
// - Flash enable clear removes flash from map
// - Extras reset: stretch 11, flash enable parameter
// - Eeprom position reset value is a parameter
// - Test locations readable, writes ignored
// - Allocation info read-only, shows switch inputs
// - Bit 7 reports 1K or 2K register space
// - Bits 5:4 report eeprom allocation size
// - Ram code reports size in 2K steps
// - Ram code selects region and position bits
// - Ram reset base follows position value 0x09
// - Smaller ram placed inside region by alignment
// - Registers decoded relative to relocatable base
// - High-align clear low end, set top end
// - Register block on 2K boundary below 32K
//
// The APB interface to the registers is this design's own decision.
`include "memory_map_config_regs.vh"

module memory_map_config_regs #(
  parameter [7:0] EE_POSITION_RESET  = `EE_POSITION_RESET,
  parameter       EE_WRITE_ONCE      = 0,
  parameter       FLASH_ENABLE_RESET = 1,
  parameter [7:0] TEST_A_VALUE       = `TEST_VALUE_RESET,
  parameter [7:0] TEST_B_VALUE       = `TEST_VALUE_RESET
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        mode_special,
  input  wire        mode_single_or_periph,
  input  wire [3:0]  register_block_position,
  input  wire [7:0]  ram_position_reg,
  input  wire        register_space_switch,
  input  wire [1:0]  eeprom_space_switch,
  input  wire [2:0]  ram_space_switch,
  output reg  [4:0]  eeprom_base_field,
  output reg  [15:0] eeprom_base_addr,
  output reg         eeprom_map_enable,
  output reg  [1:0]  external_stretch_select,
  output reg  [1:0]  stretch_cycles,
  output reg         flash_upper_half_only,
  output reg         flash_map_enable,
  output reg         flash_lower_direct_enable,
  output reg         flash_window_enable,
  output reg  [15:0] ram_base_addr,
  output reg  [15:0] ram_region_size,
  output reg  [15:0] ram_alloc_size
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // Mappable region for a ram allocation code
  function [15:0] region_size;
    input [2:0] code;
    begin
      case (code)
        3'h0: begin
          region_size = `SIZE_2K;
        end
        3'h1: begin
          region_size = `SIZE_4K;
        end
        3'h2, 3'h3: begin
          region_size = `SIZE_8K;
        end
        default: begin
          region_size = `SIZE_16K;
        end
      endcase
    end
  endfunction

  // Allocated ram size: code plus one times 2K
  function [15:0] alloc_size;
    input [2:0] code;
    reg   [3:0] steps;
    begin
      steps      = {1'b0, code} + `ONE_4;
      alloc_size = {1'b0, steps, {`PAGE_BITS{1'b0}}};
    end
  endfunction

  // Byte offset of a register index inside the block window
  function [10:0] reg_offset;
    input [7:0] idx;
    begin
      reg_offset = {1'b0, idx, 2'b00};
    end
  endfunction

  reg [1:0]  state_r;
  reg [7:0]  ee_pos_r;
  reg        ee_written_r;
  reg [1:0]  stretch_r;
  reg        upper_half_r;
  reg        flash_en_r;
  reg        misc_written_r;

  wire [7:0] rd_ee_pos;
  wire [7:0] rd_misc;
  wire [7:0] rd_memsize;
  wire       in_block;
  wire       hit_ee;
  wire       hit_misc;
  wire       hit_test_a;
  wire       hit_test_b;
  wire       hit_memsize;
  wire       hit_any;
  wire       wr_commit;
  wire       ee_field_open;
  wire       misc_open;

  reg  [7:0]  rd_value;
  reg  [15:0] ram_region_nxt;
  reg  [15:0] ram_alloc_nxt;
  reg  [15:0] ram_base_nxt;

  assign in_block = (paddr[15:`PAGE_BITS] == {1'b0, register_block_position});

  assign hit_ee      = in_block && (paddr[10:0] == reg_offset(`IDX_EEPROM_POSITION));
  assign hit_misc    = in_block && (paddr[10:0] == reg_offset(`IDX_SYSTEM_EXTRAS));
  assign hit_test_a  = in_block && (paddr[10:0] == reg_offset(`IDX_TEST_LOCATION_A));
  assign hit_test_b  = in_block && (paddr[10:0] == reg_offset(`IDX_TEST_LOCATION_B));
  assign hit_memsize = in_block && (paddr[10:0] == reg_offset(`IDX_MEMORY_ALLOC_INFO));
  assign hit_any     = hit_ee || hit_misc || hit_test_a || hit_test_b || hit_memsize;

  // Write lands only at the edge the master samples pready high
  assign wr_commit = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

  // Field lock only with the write-once option outside special modes
  assign ee_field_open = (EE_WRITE_ONCE == 0) || mode_special || !ee_written_r;

  // One write in normal and emulation, unlimited in special
  assign misc_open = mode_special || !misc_written_r;

  // Bits 2:1 of the eeprom position read zero
  assign rd_ee_pos = {ee_pos_r[`EE_BASE_MSB:`EE_BASE_LSB], 2'b00, ee_pos_r[`EE_ENABLE_BIT]};

  // Upper nibble of extras reads zero
  assign rd_misc = {`MISC_UPPER_NIBBLE, stretch_r, upper_half_r, flash_en_r};

  assign rd_memsize = {register_space_switch, 1'b0, eeprom_space_switch, 1'b0,
                       ram_space_switch};

  always @* begin
    rd_value = 8'h00;
    if (hit_ee) begin
      rd_value = rd_ee_pos;
    end else if (hit_misc) begin
      rd_value = rd_misc;
    end else if (hit_test_a) begin
      rd_value = TEST_A_VALUE;
    end else if (hit_test_b) begin
      rd_value = TEST_B_VALUE;
    end else if (hit_memsize) begin
      rd_value = rd_memsize;
    end
  end

  // One wait state: answer registered in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (psel && penable) begin
            state_r <= ST_DONE;
            pready  <= 1'b1;
            pslverr <= !hit_any;
            prdata  <= (pwrite || !hit_any) ? 32'h00000000 : {`ZERO_24, rd_value};
          end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // Eeprom position starts from the integration value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_pos_r     <= EE_POSITION_RESET;
      ee_written_r <= 1'b0;
    end else if (wr_commit && hit_ee) begin
      ee_pos_r[`EE_ENABLE_BIT] <= pwdata[`EE_ENABLE_BIT];
      if (ee_field_open) begin
        ee_pos_r[`EE_BASE_MSB:`EE_BASE_LSB] <= pwdata[`EE_BASE_MSB:`EE_BASE_LSB];
      end
      if (!mode_special) begin
        ee_written_r <= 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_r      <= `MISC_STRETCH_RESET;
      upper_half_r   <= `MISC_UPPER_HALF_RESET;
      flash_en_r     <= (FLASH_ENABLE_RESET != 0);
      misc_written_r <= 1'b0;
    end else if (wr_commit && hit_misc) begin
      if (misc_open) begin
        stretch_r    <= pwdata[`MISC_STRETCH_MSB:`MISC_STRETCH_LSB];
        upper_half_r <= pwdata[`MISC_UPPER_HALF_BIT];
        flash_en_r   <= pwdata[`MISC_FLASH_ENABLE_BIT];
      end
      if (!mode_special) begin
        misc_written_r <= 1'b1;
      end
    end
  end

  // Region and size from the allocation code
  always @* begin
    ram_region_nxt = region_size(ram_space_switch);
    ram_alloc_nxt  = alloc_size(ram_space_switch);
    // Only position bits above the region size are used
    ram_base_nxt   = {ram_position_reg[`RAM_POS_MSB:`RAM_POS_LSB], {`PAGE_BITS{1'b0}}}
                     & ~(ram_region_nxt - 16'h0001);
    // High alignment moves ram to region top
    if (ram_position_reg[`RAM_HAL_BIT]) begin
      ram_base_nxt = ram_base_nxt + ram_region_nxt - ram_alloc_nxt;
    end
  end

  // Control outputs follow registers one cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_base_field         <= 5'h00;
      eeprom_base_addr          <= `ZERO_16;
      eeprom_map_enable         <= 1'b0;
      external_stretch_select   <= `ZERO_2;
      stretch_cycles            <= `ZERO_2;
      flash_upper_half_only     <= 1'b0;
      flash_map_enable          <= 1'b0;
      flash_lower_direct_enable <= 1'b0;
      flash_window_enable       <= 1'b0;
      ram_base_addr             <= `ZERO_16;
      ram_region_size           <= `ZERO_16;
      ram_alloc_size            <= `ZERO_16;
    end else begin
      eeprom_base_field <= ee_pos_r[`EE_BASE_MSB:`EE_BASE_LSB];
      eeprom_base_addr  <= {ee_pos_r[`EE_BASE_MSB:`EE_BASE_LSB], {`PAGE_BITS{1'b0}}};
      eeprom_map_enable       <= ee_pos_r[`EE_ENABLE_BIT];
      external_stretch_select <= stretch_r;
      // Stretch count, forced zero without external bus
      stretch_cycles        <= mode_single_or_periph ? `ZERO_2 : stretch_r;
      flash_upper_half_only <= upper_half_r;
      flash_map_enable <= flash_en_r;
      // Lower fixed pages only without upper-half restriction
      flash_lower_direct_enable <= flash_en_r && !upper_half_r;
      flash_window_enable       <= flash_en_r;
      ram_base_addr             <= ram_base_nxt;
      ram_region_size           <= ram_region_nxt;
      ram_alloc_size            <= ram_alloc_nxt;
    end
  end

endmodule

//--- mmc_monitor.sv
// Concurrent checks on the memory map configuration bank ports
module mmc_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        mode_single_or_periph,
  input wire [3:0]  register_block_position,
  input wire        register_space_switch,
  input wire [1:0]  eeprom_space_switch,
  input wire [2:0]  ram_space_switch,
  input wire [4:0]  eeprom_base_field,
  input wire [15:0] eeprom_base_addr,
  input wire        eeprom_map_enable,
  input wire [1:0]  external_stretch_select,
  input wire [1:0]  stretch_cycles,
  input wire        flash_upper_half_only,
  input wire        flash_map_enable,
  input wire        flash_lower_direct_enable,
  input wire        flash_window_enable,
  input wire [15:0] ram_region_size,
  input wire [15:0] ram_alloc_size
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [15:0] base = {1'b0, register_block_position, 11'h000};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ee_wr;
    pready && !pslverr && pwrite && pstrb[0] && paddr == base + 16'h0048;
  endsequence
  property p_ee_delay;
    s_ee_wr |=> $stable(eeprom_map_enable) ##1 eeprom_map_enable == $past(pwdata[0], 2);
  endproperty
  a_ee_delay: assert property (p_ee_delay) else $error("eeprom enable timing");
  property p_base;
    eeprom_base_addr == {eeprom_base_field, 11'h000};
  endproperty
  a_base: assert property (p_base) else $error("eeprom base address");
  property p_flash;
    flash_lower_direct_enable == (flash_map_enable && !flash_upper_half_only)
      && flash_window_enable == flash_map_enable;
  endproperty
  a_flash: assert property (p_flash) else $error("flash enables");
  property p_stretch;
    stretch_cycles == ($past(mode_single_or_periph) ? 2'h0 : external_stretch_select);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch cycles");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err;
    pslverr |-> pready && psel && penable && $past(penable);
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unmapped;
    pready && paddr[15:11] != base[15:11] |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("foreign address accepted");
  property p_alloc;
    pready && !pwrite && paddr == base + 16'h0070 |-> prdata == {24'h000000,
      register_space_switch, 1'b0, eeprom_space_switch, 1'b0, ram_space_switch};
  endproperty
  a_alloc: assert property (p_alloc) else $error("allocation read");
  property p_ram_alloc;
    $past(presetn) |->
      ram_alloc_size == (({13'h0000, $past(ram_space_switch)} + 16'h0001) << 11);
  endproperty
  a_ram_alloc: assert property (p_ram_alloc) else $error("ram size");
  property p_region;
    $past(presetn) |-> ram_region_size == ($past(ram_space_switch) == 3'h0 ? 16'h0800 :
      $past(ram_space_switch) == 3'h1 ? 16'h1000 :
      !$past(ram_space_switch[2]) ? 16'h2000 : 16'h4000);
  endproperty
  a_region: assert property (p_region) else $error("ram region");
endmodule

bind memory_map_config_regs mmc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mode_single_or_periph(mode_single_or_periph),
  .register_block_position(register_block_position),
  .register_space_switch(register_space_switch), .eeprom_space_switch(eeprom_space_switch),
  .ram_space_switch(ram_space_switch), .eeprom_base_field(eeprom_base_field),
  .eeprom_base_addr(eeprom_base_addr), .eeprom_map_enable(eeprom_map_enable),
  .external_stretch_select(external_stretch_select), .stretch_cycles(stretch_cycles),
  .flash_upper_half_only(flash_upper_half_only), .flash_map_enable(flash_map_enable),
  .flash_lower_direct_enable(flash_lower_direct_enable),
  .flash_window_enable(flash_window_enable), .ram_region_size(ram_region_size),
  .ram_alloc_size(ram_alloc_size));

//--- core_strap_model.sv
// Integration straps and ram position value seen at the core boundary
module core_strap_model (
  input  wire [2:0] cfg,
  input  wire       hal,
  output wire       register_space_switch,
  output wire [1:0] eeprom_space_switch,
  output wire [2:0] ram_space_switch,
  output wire [7:0] ram_position_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps are wired levels, so they are derived from one code to sweep all of them
  assign register_space_switch = cfg[2];
  assign eeprom_space_switch   = cfg[1:0];
  assign ram_space_switch      = cfg;
  assign ram_position_reg = {5'h01, 2'h0, hal};
endmodule

//--- tb_top.sv
// Directed APB testbench for the memory map configuration bank
`include "memory_map_config_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] EE = `IDX_EEPROM_POSITION * 4;
  localparam logic [15:0] MI = `IDX_SYSTEM_EXTRAS * 4;
  localparam logic [15:0] TA = `IDX_TEST_LOCATION_A * 4;
  localparam logic [15:0] TB = `IDX_TEST_LOCATION_B * 4;
  localparam logic [15:0] AL = `IDX_MEMORY_ALLOC_INFO * 4;
  localparam logic [15:0] RB [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000,
                                     16'h1800, 16'h1000, 16'h0800, 16'h0000};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        ms = 0, msp = 0, hal = 1;
  logic [15:0] paddr = 16'h0000, base = 16'h1000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [3:0]  pstrb = 4'hF, rbp = 4'h2;
  logic [2:0]  cfg = 3'h0;
  wire  [31:0] prdata;
  wire  [15:0] eba, rba, rrs, ras;
  wire  [7:0]  rpos;
  wire  [4:0]  ebf;
  wire  [2:0]  rsw;
  wire  [1:0]  esw, ess, sc;
  wire         pready, pslverr, rss, eme, fuh, fme, fld, fwe;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, i;
  core_strap_model strap (.cfg(cfg), .hal(hal), .register_space_switch(rss),
    .eeprom_space_switch(esw), .ram_space_switch(rsw), .ram_position_reg(rpos));
  memory_map_config_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_special(ms),
    .mode_single_or_periph(msp), .register_block_position(rbp), .ram_position_reg(rpos),
    .register_space_switch(rss), .eeprom_space_switch(esw), .ram_space_switch(rsw),
    .eeprom_base_field(ebf), .eeprom_base_addr(eba), .eeprom_map_enable(eme),
    .external_stretch_select(ess), .stretch_cycles(sc), .flash_upper_half_only(fuh),
    .flash_map_enable(fme), .flash_lower_direct_enable(fld), .flash_window_enable(fwe),
    .ram_base_addr(rba), .ram_region_size(rrs), .ram_alloc_size(ras));
  initial forever #2.5 pclk = ~pclk;
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hang ends the run as a failure
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task xfer(input logic w, input logic [15:0] off, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= base + off;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input string nm, input logic [15:0] off, input logic [31:0] e);
    xfer(0, off, 32'h00000000);
    chk(nm, rd, e);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rdchk("ee_reset", EE, 32'h00000001);
    rdchk("misc_reset", MI, 32'h0000000D);
    chk("stretch_reset", sc, 32'h3);
    xfer(1, EE, 32'h000000FF);
    rdchk("ee_pad_bits", EE, 32'h000000F9);
    chk("ee_base", eba, 32'hF800);
    pstrb <= 4'hE;
    xfer(1, EE, 32'h00000000);
    pstrb <= 4'hF;
    rdchk("ee_strobe", EE, 32'h000000F9);
    xfer(1, EE, 32'h000000A8);
    rdchk("ee_rewrite", EE, 32'h000000A8);
    chk("ee_enable", eme, 32'h0);
    xfer(1, TA, 32'h000000FF);
    xfer(1, TB, 32'h000000FF);
    xfer(1, AL, 32'h000000FF);
    chk("ro_write_err", err, 32'h0);
    rdchk("test_a", TA, 32'h00000000);
    rdchk("test_b", TB, 32'h00000000);
    xfer(1, MI, 32'h00000007);
    repeat (3) @(posedge pclk);
    chk("lower_direct", fld, 32'h0);
    chk("upper_half", fuh, 32'h1);
    chk("stretch_one", sc, 32'h1);
    xfer(1, MI, 32'h0000000C);
    rdchk("misc_locked", MI, 32'h00000007);
    ms <= 1;
    for (i = 0; i < 4; i++) begin
      xfer(1, MI, 32'(i * 4 + 1));
      repeat (3) @(posedge pclk);
      chk("stretch_code", sc, 32'(i));
    end
    chk("lower_open", fld, 32'h1);
    xfer(1, MI, 32'h0000000C);
    repeat (3) @(posedge pclk);
    chk("flash_off", fme, 32'h0);
    msp <= 1;
    repeat (3) @(posedge pclk);
    chk("stretch_masked", sc, 32'h0);
    xfer(0, 16'h0004, 32'h00000000);
    chk("unmapped", err, 32'h1);
    rbp <= 4'h5;
    xfer(0, EE, 32'h00000000);
    chk("old_base", err, 32'h1);
    base <= 16'h2800;
    rdchk("moved", EE, 32'h000000A8);
    for (i = 0; i < 8; i++) begin
      cfg <= i[2:0];
      repeat (3) @(posedge pclk);
      chk("ram_base", rba, RB[i]);
      chk("ram_alloc", ras, 32'((i + 1) * 2048));
      rdchk("alloc", AL, {24'h000000, i[2], 1'b0, i[1:0], 1'b0, i[2:0]});
    end
    hal <= 0;
    cfg <= 3'h4;
    repeat (3) @(posedge pclk);
    chk("ram_low_align", rba, 32'h0000);
    give_verdict;
  end
endmodule
